// ---- gfd_pkg.sv ----
// package: constants, carrier types and state layout of the ground fault direction block
package gfd_pkg;
    // register byte offsets on the wishbone slave
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_NV_MIN = 8'h04;
    localparam logic [7:0] OFF_REL_DLY = 8'h08;
    localparam logic [7:0] OFF_IMIN_M = 8'h0C;
    localparam logic [7:0] OFF_IMIN_C = 8'h10;
    localparam logic [7:0] OFF_CHAR = 8'h14;
    localparam logic [7:0] OFF_CORR = 8'h18;
    localparam logic [7:0] OFF_LIM_M = 8'h1C;
    localparam logic [7:0] OFF_LIM_C = 8'h20;
    localparam logic [7:0] OFF_PICKUP = 8'h24;
    localparam logic [7:0] OFF_OP_DLY = 8'h28;
    localparam logic [7:0] OFF_STATUS = 8'h2C;
    localparam int NUM_RW = 11;
    // control register fields
    localparam int CTRL_PROT_EN = 0;
    localparam int CTRL_MOD_EN = 1;
    localparam int CTRL_TCB = 2;
    localparam int CTRL_SUP = 3;
    localparam int CTRL_REV = 4;
    localparam int CTRL_SENS = 5;
    localparam int CTRL_SRC_C = 6;
    localparam int CTRL_MSEL = 8;
    localparam int CTRL_CSEL = 12;
    localparam int LIM_TWO = 16;
    localparam int CHAR_PHASE = 16;
    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0003;
    localparam logic [31:0] NV_MIN_RST = 32'h0000_0064;
    localparam logic [31:0] IMIN_RST = 32'h0000_0014;
    localparam logic [31:0] PICKUP_RST = 32'h0000_0064;
    // residual minimum range, units of 0.001 nominal current
    localparam logic [15:0] IMIN_STD_LO = 16'h0014;
    localparam logic [15:0] IMIN_SENS_LO = 16'h0002;
    localparam logic [15:0] IMIN_HI = 16'h07D0;
    // angles: 12 bits per full turn
    localparam logic [11:0] ANG_0 = 12'h000;
    localparam logic [11:0] ANG_90 = 12'h400;
    localparam logic [11:0] ANG_180 = 12'h800;
    // smallest magnitude usable for evaluation
    localparam logic [15:0] EVAL_MIN = 16'h0010;
    // timing: milliseconds at the tick rate
    localparam int CLK_NS = 50;
    localparam int MS_NS = 1000000;
    localparam int CYC_PER_MS = (MS_NS + CLK_NS - 1) / CLK_NS;
    // direction methods (control field codes)
    typedef enum logic [2:0] {M_RES_NV, M_NEG_SEQ, M_DUAL, M_WATT, M_REACT, M_CUR_POL} gfd_meth_type;
    typedef struct packed {
        logic [15:0] mag;
        logic [11:0] ang;
    } gfd_phasor_type;
    typedef struct packed {
        gfd_phasor_type i_meas;
        gfd_phasor_type i_calc;
        gfd_phasor_type v_neut;
        gfd_phasor_type v_neg;
        gfd_phasor_type i_neg;
        logic signed [16:0] act_m;
        logic signed [16:0] rea_m;
        logic signed [16:0] act_c;
        logic signed [16:0] rea_c;
    } gfd_meas_type;
    typedef struct packed {
        logic [NUM_RW-1:0][31:0] regs;
        logic [15:0] tick;
        logic [15:0] rel_cnt;
        logic rel;
        logic fwd;
        logic rev;
        logic nposs;
        logic pick;
        logic [15:0] op_cnt;
        logic trip;
        logic tcmd;
        logic galm;
        logic gtrp;
        logic ack;
        logic [31:0] rdat;
    } gfd_state_type;
endpackage : gfd_pkg

// ---- gfd_top.sv ----
// ground fault direction decision, release timer, element gating, wishbone registers
`timescale 1ns/1ps
// Summary of operation
// - angle methods decide by operating/polarizing angle
// - measured dual: negative sequence else residual
// - computed dual: measured current polarizes else voltage
// - release only above neutral voltage minimum
// - release after delay from threshold crossing
// - release delay adds to element delay
// - wattmetric/reactive component against residual minimum
// - standard input minimum 0.02 to 2.00
// - sensitive input minimum 0.002 to 2.00
// - two limit angles shrink enabling region
// - computed current has own minimum, limits
// - correct ground current angle before evaluation
// - element works forward only or reverse only
// - supervision only: no alarm, trip, command
// - global enable off stops all protection
// - module enable switches element on/off
// - trip command block suppresses breaker command
// - boundary perpendicular to direction angle
// - small phasors report direction not possible
module gfd_top #(
    parameter int unsigned MS_CYCLES = gfd_pkg::CYC_PER_MS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire gfd_pkg::gfd_meas_type meas_i,
    output logic dir_fwd_o,
    output logic dir_rev_o,
    output logic dir_nposs_o,
    output logic dir_rel_o,
    output logic pickup_o,
    output logic trip_cmd_o,
    output logic gen_alarm_o,
    output logic gen_trip_o
);
    // register index of a byte address, 4'hF when unmapped
    function automatic logic [3:0] reg_idx(input logic [7:0] a);
        if (a[1:0] != 2'h0 || a > gfd_pkg::OFF_STATUS) begin
            return 4'hF;
        end
        return a[5:2];
    endfunction : reg_idx

    // byte lane merge for writes
    function automatic logic [31:0] lane_mrg(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[8*b +: 8] = n[8*b +: 8];
            end
        end
        return r;
    endfunction : lane_mrg

    // keep a residual minimum inside the range of the input kind
    function automatic logic [31:0] imin_fix(input logic [31:0] v, input logic sens);
        logic [15:0] lo;
        lo = sens ? gfd_pkg::IMIN_SENS_LO : gfd_pkg::IMIN_STD_LO;
        if (v[15:0] < lo) begin
            return {16'h0000, lo};
        end
        if (v[15:0] > gfd_pkg::IMIN_HI) begin
            return {16'h0000, gfd_pkg::IMIN_HI};
        end
        return {16'h0000, v[15:0]};
    endfunction : imin_fix

    // half plane test around the direction angle, returns {rev, fwd}
    function automatic logic [1:0] half_plane(input logic [11:0] d);
        logic signed [11:0] s;
        s = $signed(d);
        return {(s > $signed(gfd_pkg::ANG_90)) || (s < -$signed(gfd_pkg::ANG_90)),
                (s < $signed(gfd_pkg::ANG_90)) && (s > -$signed(gfd_pkg::ANG_90))};
    endfunction : half_plane

    // true when angle d sits inside the window narrowed by l1 and l2
    function automatic logic in_win(input logic [11:0] d, input logic [11:0] l1, input logic [11:0] l2);
        logic signed [12:0] a;
        logic signed [12:0] lo;
        logic signed [12:0] hi;
        a = {d[11], d};
        lo = $signed({1'b0, gfd_pkg::ANG_90}) - $signed({1'b0, l1});
        hi = $signed({1'b0, gfd_pkg::ANG_90}) - $signed({1'b0, l2});
        return (a > -lo) && (a < hi);
    endfunction : in_win

    // phasor large enough to evaluate
    function automatic logic usable(input gfd_pkg::gfd_phasor_type p);
        return p.mag >= gfd_pkg::EVAL_MIN;
    endfunction : usable

    gfd_pkg::gfd_state_type s_q; // whole block state
    gfd_pkg::gfd_state_type s_d; // next state

    // settings views
    logic [31:0] ctrl; // control word
    logic src_c; // computed current operates
    logic [2:0] meth; // selected method code
    logic [11:0] gca; // ground characteristic angle
    logic [11:0] pca; // phase characteristic angle
    logic [11:0] corr_ang; // ground ct angle correction
    logic [31:0] lim; // limit angle pair in use
    logic [15:0] imin; // residual minimum in use
    logic [15:0] rdly; // release delay, ms
    logic [15:0] rel_cnt; // release timer view
    logic above; // neutral voltage above minimum

    // decision intermediates
    gfd_pkg::gfd_phasor_type op; // operating quantity
    logic [11:0] ig_ang; // corrected measured current angle
    logic [11:0] pol_ang; // polarizing angle
    logic [11:0] chr; // direction angle
    logic pol_ok; // polarizing quantity usable
    logic op_ok; // operating quantity usable
    logic illegal; // method code not offered
    logic sect; // wattmetric/reactive sector method
    logic signed [16:0] comp; // active or reactive component
    logic [11:0] dsec; // sector angle
    logic [1:0] raw; // {rev, fwd} before release
    logic npos; // evaluation impossible
    logic ms; // millisecond tick
    logic en; // element enabled
    logic [3:0] idx; // bus register index

    // settings decode from state
    always_comb begin
        ctrl = s_q.regs[gfd_pkg::OFF_CTRL[5:2]];
        src_c = ctrl[gfd_pkg::CTRL_SRC_C];
        meth = src_c ? ctrl[gfd_pkg::CTRL_CSEL +: 3] : ctrl[gfd_pkg::CTRL_MSEL +: 3];
        gca = s_q.regs[gfd_pkg::OFF_CHAR[5:2]][11:0];
        pca = s_q.regs[gfd_pkg::OFF_CHAR[5:2]][gfd_pkg::CHAR_PHASE +: 12];
        corr_ang = s_q.regs[gfd_pkg::OFF_CORR[5:2]][11:0];
        // computed current uses its own minimum and limits
        lim = src_c ? s_q.regs[gfd_pkg::OFF_LIM_C[5:2]] : s_q.regs[gfd_pkg::OFF_LIM_M[5:2]];
        imin = src_c ? s_q.regs[gfd_pkg::OFF_IMIN_C[5:2]][15:0] : s_q.regs[gfd_pkg::OFF_IMIN_M[5:2]][15:0];
        rdly = s_q.regs[gfd_pkg::OFF_REL_DLY[5:2]][15:0];
        rel_cnt = s_q.rel_cnt;
        above = meas_i.v_neut.mag > s_q.regs[gfd_pkg::OFF_NV_MIN[5:2]][15:0];
        en = ctrl[gfd_pkg::CTRL_PROT_EN] && ctrl[gfd_pkg::CTRL_MOD_EN];
        idx = reg_idx(adr_i);
        ms = s_q.tick == 16'(MS_CYCLES - 1);
    end

    // quantity selection per method
    always_comb begin
        ig_ang = meas_i.i_meas.ang + corr_ang;
        op = src_c ? meas_i.i_calc : gfd_pkg::gfd_phasor_type'{mag: meas_i.i_meas.mag, ang: ig_ang};
        pol_ang = meas_i.v_neut.ang;
        pol_ok = usable(meas_i.v_neut);
        chr = gca;
        illegal = 1'b0;
        sect = 1'b0;
        comp = src_c ? meas_i.act_c : meas_i.act_m;
        unique case (meth)
            3'(gfd_pkg::M_RES_NV): begin
            end
            3'(gfd_pkg::M_NEG_SEQ): begin
                op = meas_i.i_neg;
                pol_ang = meas_i.v_neg.ang;
                pol_ok = usable(meas_i.v_neg);
                chr = gfd_pkg::ANG_90 + pca;
            end
            3'(gfd_pkg::M_DUAL): begin
                if (!src_c && usable(meas_i.v_neg) && usable(meas_i.i_neg)) begin
                    // negative sequence preferred when present
                    op = meas_i.i_neg;
                    pol_ang = meas_i.v_neg.ang;
                    pol_ok = 1'b1;
                    chr = gfd_pkg::ANG_90 + pca;
                end else if (src_c && usable(meas_i.i_meas)) begin
                    // measured current polarizes the computed one
                    pol_ang = ig_ang;
                    pol_ok = 1'b1;
                    chr = gfd_pkg::ANG_0;
                end
            end
            3'(gfd_pkg::M_CUR_POL): begin
                pol_ang = ig_ang;
                pol_ok = usable(meas_i.i_meas);
                chr = gfd_pkg::ANG_0;
                illegal = !src_c;
            end
            3'(gfd_pkg::M_WATT): begin
                sect = 1'b1;
            end
            3'(gfd_pkg::M_REACT): begin
                sect = 1'b1;
                comp = src_c ? meas_i.rea_c : meas_i.rea_m;
            end
            default: begin
                illegal = 1'b1;
            end
        endcase
        op_ok = usable(op);
        npos = illegal || !op_ok || !pol_ok;
        // reactive method looks a quarter turn away from the voltage
        dsec = op.ang - pol_ang - (meth == 3'(gfd_pkg::M_REACT) ? gfd_pkg::ANG_90 : gfd_pkg::ANG_0);
        if (npos) begin
            raw = 2'h0;
        end else if (sect) begin
            // component must pass the minimum inside the narrowed window
            raw[0] = comp >= $signed({1'b0, imin}) && in_win(dsec, lim[11:0], lim[gfd_pkg::LIM_TWO +: 12]);
            raw[1] = comp <= -$signed({1'b0, imin})
                && in_win(dsec + gfd_pkg::ANG_180, lim[11:0], lim[gfd_pkg::LIM_TWO +: 12]);
        end else begin
            raw = half_plane(op.ang - pol_ang - chr);
        end
    end

    // next state: bus, release timer, element
    always_comb begin
        s_d = s_q;
        s_d.tick = ms ? 16'h0000 : s_q.tick + 16'h0001;
        // wishbone classic: answer one cycle after the request
        s_d.ack = cyc_i && stb_i && !s_q.ack;
        s_d.rdat = 32'h0000_0000;
        if (cyc_i && stb_i && !s_q.ack) begin
            if (we_i && idx < 4'(gfd_pkg::NUM_RW)) begin
                s_d.regs[idx] = lane_mrg(s_q.regs[idx], dat_i, sel_i);
            end
            if (idx < 4'(gfd_pkg::NUM_RW)) begin
                s_d.regs[idx] = s_d.regs[idx];
                s_d.rdat = s_q.regs[idx];
            end else if (idx == gfd_pkg::OFF_STATUS[5:2]) begin
                s_d.rdat = {23'h000000, s_q.gtrp, s_q.galm, s_q.tcmd, s_q.trip, s_q.pick,
                            s_q.nposs, s_q.rev, s_q.fwd, s_q.rel};
            end
        end
        // residual minimum kept inside the range of the input kind
        s_d.regs[gfd_pkg::OFF_IMIN_M[5:2]] = imin_fix(s_d.regs[gfd_pkg::OFF_IMIN_M[5:2]],
            ctrl[gfd_pkg::CTRL_SENS]);
        s_d.regs[gfd_pkg::OFF_IMIN_C[5:2]] = imin_fix(s_d.regs[gfd_pkg::OFF_IMIN_C[5:2]],
            ctrl[gfd_pkg::CTRL_SENS]);
        // release timer runs while voltage stays above minimum
        if (!above) begin
            s_d.rel_cnt = 16'h0000;
            s_d.rel = 1'b0;
        end else if (!s_q.rel) begin
            if (s_q.rel_cnt >= rdly) begin
                s_d.rel = 1'b1;
            end else if (ms) begin
                s_d.rel_cnt = s_q.rel_cnt + 16'h0001;
            end
        end
        // released results only
        s_d.fwd = s_d.rel && raw[0];
        s_d.rev = s_d.rel && raw[1];
        s_d.nposs = npos;
        // element follows the chosen direction only
        s_d.pick = en && (ctrl[gfd_pkg::CTRL_REV] ? s_q.rev : s_q.fwd)
            && op.mag >= s_q.regs[gfd_pkg::OFF_PICKUP[5:2]][15:0];
        // operate timer starts only after release, so delays add
        if (!s_d.pick) begin
            s_d.op_cnt = 16'h0000;
            s_d.trip = 1'b0;
        end else if (s_q.op_cnt >= s_q.regs[gfd_pkg::OFF_OP_DLY[5:2]][15:0]) begin
            s_d.trip = 1'b1;
        end else if (ms) begin
            s_d.op_cnt = s_q.op_cnt + 16'h0001;
        end
        // supervision only and command block gating
        s_d.galm = s_d.pick && !ctrl[gfd_pkg::CTRL_SUP];
        s_d.gtrp = s_d.trip && !ctrl[gfd_pkg::CTRL_SUP];
        s_d.tcmd = s_d.trip && !ctrl[gfd_pkg::CTRL_SUP] && !ctrl[gfd_pkg::CTRL_TCB];
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.regs[gfd_pkg::OFF_CTRL[5:2]] <= gfd_pkg::CTRL_RST;
            s_q.regs[gfd_pkg::OFF_NV_MIN[5:2]] <= gfd_pkg::NV_MIN_RST;
            s_q.regs[gfd_pkg::OFF_IMIN_M[5:2]] <= gfd_pkg::IMIN_RST;
            s_q.regs[gfd_pkg::OFF_IMIN_C[5:2]] <= gfd_pkg::IMIN_RST;
            s_q.regs[gfd_pkg::OFF_PICKUP[5:2]] <= gfd_pkg::PICKUP_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from state
    assign dat_o = s_q.rdat;
    assign ack_o = s_q.ack;
    assign dir_fwd_o = s_q.fwd;
    assign dir_rev_o = s_q.rev;
    assign dir_nposs_o = s_q.nposs;
    assign dir_rel_o = s_q.rel;
    assign pickup_o = s_q.pick;
    assign trip_cmd_o = s_q.tcmd;
    assign gen_alarm_o = s_q.galm;
    assign gen_trip_o = s_q.gtrp;

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_prot_off_quiet: assert property (!ctrl[gfd_pkg::CTRL_PROT_EN] |=> !pickup_o && !s_q.trip)
        else $error("pickup or trip with protection disabled");
    a_module_off_quiet: assert property (!ctrl[gfd_pkg::CTRL_MOD_EN] |=> !pickup_o && !s_q.trip)
        else $error("element active while switched off");
    a_block_no_cmd: assert property (ctrl[gfd_pkg::CTRL_TCB] |=> !trip_cmd_o)
        else $error("trip command while blocked");
    a_superv_silent: assert property (ctrl[gfd_pkg::CTRL_SUP] |=>
        !gen_alarm_o && !gen_trip_o && !trip_cmd_o)
        else $error("supervision element raised alarm or trip");
    a_nv_low_drop: assert property (!above |=>
        !dir_rel_o && !dir_fwd_o && !dir_rev_o && rel_cnt == 16'h0000)
        else $error("direction kept with low neutral voltage");
    a_release_wait: assert property ($rose(dir_rel_o) |-> $past(rel_cnt) >= $past(rdly) && $past(above))
        else $error("release before delay expired");
    a_nposs_excl: assert property (dir_nposs_o && !$past(above, 1) |-> !dir_fwd_o && !dir_rev_o)
        else $error("direction given while not possible");
    a_mode_match: assert property ($rose(pickup_o) |->
        $past(ctrl[gfd_pkg::CTRL_REV] ? dir_rev_o : dir_fwd_o))
        else $error("pickup against configured direction");
    // pickup needs a released direction one cycle earlier, trip rises with it or after the operate delay
    a_trip_after_rel: assert property ($rose(s_q.trip) |-> $past(dir_rel_o, 1))
        else $error("trip without prior direction release");
    a_imin_range: assert property (!ctrl[gfd_pkg::CTRL_SENS] |=>
        imin >= gfd_pkg::IMIN_STD_LO && imin <= gfd_pkg::IMIN_HI)
        else $error("standard residual minimum out of range");
    // bus answer checks
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held two cycles");
    a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0000_0000)
        else $error("read data outside acknowledge");

    // main scenarios reached
    c_fwd_release: cover property (above ##1 dir_rel_o && dir_fwd_o);
    c_rev_trip: cover property (ctrl[gfd_pkg::CTRL_REV] && trip_cmd_o);
    c_not_possible: cover property (above && dir_nposs_o);
    c_delay_release: cover property ($rose(dir_rel_o) && rdly != 16'h0000);
    c_dual_polarize: cover property (meth == 3'(gfd_pkg::M_DUAL) && src_c && dir_fwd_o);
endmodule : gfd_top

// ---- gfd_meas_model.sv ----
// measurement front end model: phasors and components that feed the block
`timescale 1ns/1ps
module gfd_meas_model (
    input wire logic [15:0] v_mag_i,
    input wire logic [15:0] i_mag_i,
    input wire logic [11:0] i_ang_i,
    input wire logic signed [16:0] act_i,
    output gfd_pkg::gfd_meas_type meas_o
);
    // neutral voltage at angle zero, both residual currents alike, no negative sequence
    always_comb begin
        meas_o.i_meas.mag = i_mag_i;
        meas_o.i_meas.ang = i_ang_i;
        meas_o.i_calc.mag = i_mag_i;
        meas_o.i_calc.ang = i_ang_i;
        meas_o.v_neut.mag = v_mag_i;
        meas_o.v_neut.ang = 12'h000;
        meas_o.v_neg = '0; // too small to use
        meas_o.i_neg = '0;
        meas_o.act_m = act_i;
        meas_o.rea_m = 17'sh00000;
        meas_o.act_c = act_i;
        meas_o.rea_c = 17'sh00000;
    end
endmodule : gfd_meas_model

// ---- gfd_top_tb.sv ----
// self-checking bench of the ground fault direction block
`timescale 1ns/1ps
module gfd_top_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [3:0] sel_i = 4'hF;
    logic we_i = 1'b0;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic [15:0] v_mag = 16'h0000; // neutral voltage magnitude
    logic [15:0] i_mag = 16'h0200; // residual current magnitude
    logic [11:0] i_ang = 12'h000;
    logic signed [16:0] act = 17'sh00100; // active component
    logic [31:0] dat_o;
    logic ack_o;
    gfd_pkg::gfd_meas_type meas_i;
    logic dir_fwd_o, dir_rev_o, dir_nposs_o, dir_rel_o, pickup_o, trip_cmd_o, gen_alarm_o, gen_trip_o;
    logic [7:0] outs; // all result outputs in one vector
    logic [7:0] seen; // outputs seen high in a window
    logic [31:0] rd;
    int miscompares = 0;
    int total_checks = 0;
    // 20 MHz tick
    always #25 clk_i = ~clk_i;
    assign outs = {gen_trip_o, gen_alarm_o, trip_cmd_o, pickup_o, dir_rel_o, dir_nposs_o, dir_rev_o, dir_fwd_o};
    gfd_meas_model gfd_meas_model_i (.v_mag_i(v_mag), .i_mag_i(i_mag), .i_ang_i(i_ang), .act_i(act), .meas_o(meas_i));
    gfd_top #(.MS_CYCLES(4)) gfd_top_i (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
        .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .meas_i(meas_i),
        .dir_fwd_o(dir_fwd_o), .dir_rev_o(dir_rev_o), .dir_nposs_o(dir_nposs_o), .dir_rel_o(dir_rel_o),
        .pickup_o(pickup_o), .trip_cmd_o(trip_cmd_o), .gen_alarm_o(gen_alarm_o), .gen_trip_o(gen_trip_o));
    // verdict and end of run
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run
    // compare a result against expected
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    // one classic wishbone cycle, held until ack
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        adr_i <= a;
        we_i <= w;
        dat_i <= d;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_i);
            if (ack_o === 1'b1) break;
        end
        rd = dat_o;
        if (n == 20) begin
            miscompares++;
            complete_run();
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask : wb
    // read and compare
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        wb(a, 1'b0, 32'h0000_0000);
        check(rd, exp, what);
    endtask : rdchk
    // gather outputs over n ticks
    task automatic watch(input int n);
        seen = 8'h00;
        repeat (n) begin
            @(posedge clk_i);
            seen = seen | outs;
        end
    endtask : watch
    // apply neutral voltage above minimum, watch, then remove it
    task automatic run(input logic [11:0] ang, input int n);
        @(posedge clk_i);
        i_ang <= ang;
        v_mag <= 16'h0200;
        @(posedge clk_i);
        watch(n);
        @(posedge clk_i);
        v_mag <= 16'h0000;
        repeat (4) @(posedge clk_i);
    endtask : run
    // reset values, refused addresses
    task automatic t_regs;
        rdchk(gfd_pkg::OFF_CTRL, gfd_pkg::CTRL_RST, "ctrl reset");
        rdchk(gfd_pkg::OFF_NV_MIN, gfd_pkg::NV_MIN_RST, "voltage min reset");
        rdchk(gfd_pkg::OFF_IMIN_C, gfd_pkg::IMIN_RST, "computed min reset");
        rdchk(gfd_pkg::OFF_REL_DLY, 32'h0000_0000, "delay reset");
        wb(gfd_pkg::OFF_STATUS, 1'b1, 32'hFFFF_FFFF);
        rdchk(gfd_pkg::OFF_STATUS, 32'h0000_0008, "status read only");
        rdchk(8'h3C, 32'h0000_0000, "unmapped read");
        $display("register test done");
    endtask : t_regs
    // forward release, trip chain, withdrawal
    task automatic t_fwd;
        @(posedge clk_i);
        v_mag <= 16'h0200;
        @(posedge clk_i);
        watch(4);
        check(seen[3:0], 4'h9, "release forward");
        watch(4);
        check(seen[7:4], 4'hF, "pickup and trip");
        @(posedge clk_i);
        v_mag <= 16'h0020;
        watch(2);
        watch(4);
        check(seen[3:0], 4'h0, "withdrawn");
        repeat (4) @(posedge clk_i);
        $display("forward test done");
    endtask : t_fwd
    // release delay of 2 ms ticks
    task automatic t_delay;
        wb(gfd_pkg::OFF_REL_DLY, 1'b1, 32'h0000_0002);
        @(posedge clk_i);
        v_mag <= 16'h0200;
        watch(3);
        check(seen[7:3], 5'h00, "early release");
        watch(16);
        check(seen[3], 1'b1, "late release");
        run(12'h000, 1);
        wb(gfd_pkg::OFF_REL_DLY, 1'b1, 32'h0000_0000);
        $display("delay test done");
    endtask : t_delay
    // reverse mode, direction not possible
    task automatic t_rev;
        wb(gfd_pkg::OFF_CTRL, 1'b1, 32'h0000_0013);
        run(gfd_pkg::ANG_180, 8);
        check(seen[4:0], 5'h1A, "reverse picks up");
        run(gfd_pkg::ANG_0, 8);
        check(seen[4:0], 5'h09, "forward ignored");
        wb(gfd_pkg::OFF_CTRL, 1'b1, 32'h0000_0003);
        @(posedge clk_i);
        i_mag <= 16'h0004;
        run(gfd_pkg::ANG_0, 4);
        check(seen[2:0], 3'h4, "not possible");
        i_mag <= 16'h0200;
        $display("reverse test done");
    endtask : t_rev
    // one gating setting, masked outputs compared
    task automatic t_gate(input logic [31:0] ctrl, input logic [7:0] mask, input logic [7:0] exp);
        wb(gfd_pkg::OFF_CTRL, 1'b1, ctrl);
        run(gfd_pkg::ANG_0, 8);
        check(seen & mask, exp, "gating");
    endtask : t_gate
    // wattmetric minimum, input range, limit angles
    task automatic t_watt;
        wb(gfd_pkg::OFF_IMIN_M, 1'b1, 32'h0000_0001);
        wb(gfd_pkg::OFF_CTRL, 1'b1, 32'h0000_0303);
        act <= 17'sh00005;
        run(gfd_pkg::ANG_0, 6);
        check(seen[0], 1'b0, "standard clamp");
        wb(gfd_pkg::OFF_CTRL, 1'b1, 32'h0000_0323);
        wb(gfd_pkg::OFF_IMIN_M, 1'b1, 32'h0000_0001);
        run(gfd_pkg::ANG_0, 6);
        check(seen[0], 1'b1, "sensitive range");
        act <= 17'sh00100;
        run(12'hE00, 6);
        check(seen[0], 1'b1, "wide region");
        wb(gfd_pkg::OFF_LIM_M, 1'b1, 32'h0000_0300);
        run(12'hE00, 6);
        check(seen[0], 1'b0, "limited region");
        $display("wattmetric test done");
    endtask : t_watt
    // computed dual, measured dual fallback, missing negative sequence, angle correction
    task automatic t_meth;
        wb(gfd_pkg::OFF_CTRL, 1'b1, 32'h0000_2043);
        run(gfd_pkg::ANG_180, 4);
        check(seen[2:0], 3'h1, "measured current polarizes");
        wb(gfd_pkg::OFF_CTRL, 1'b1, 32'h0000_0203);
        run(gfd_pkg::ANG_180, 4);
        check(seen[2:0], 3'h2, "dual falls back");
        wb(gfd_pkg::OFF_CTRL, 1'b1, 32'h0000_0103);
        run(gfd_pkg::ANG_0, 4);
        check(seen[2:0], 3'h4, "no negative sequence");
        wb(gfd_pkg::OFF_CTRL, 1'b1, 32'h0000_0003);
        wb(gfd_pkg::OFF_CORR, 1'b1, {20'h00000, gfd_pkg::ANG_180});
        run(gfd_pkg::ANG_0, 4);
        check(seen[2:0], 3'h2, "angle correction");
        $display("method test done");
    endtask : t_meth
    // main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_fwd();
        t_delay();
        t_rev();
        t_gate(32'h0000_0007, 8'h30, 8'h10);
        t_gate(32'h0000_000B, 8'hE0, 8'h00);
        t_gate(32'h0000_0002, 8'hF0, 8'h00);
        t_gate(32'h0000_0001, 8'hF0, 8'h00);
        $display("gating test done");
        t_watt();
        t_meth();
        complete_run();
    end
endmodule : gfd_top_tb
